// >>> logic/pwr_out_route.sv
// output routing, pin enable, converter sync and interrupts of three units
// assumes the counter engines report on pwr_unit_in_s in the sys_clk domain
// and an avalon-mm master that holds its request until waitrequest is low
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// R01: each unit has end-cycle and capture interrupts
// R02: end-cycle flag on counter match with reset-b
// R03: capture flag on retrigger, capture or sync error
// R04: vectors one to six, unit two first
// R05: out3 takes b when clear, a when set
// R06: out2 takes a when clear, b when set
// R07: ramp modes: leading edges send converter sync
// R08: ramp modes: trailing edge or fault sends sync
// R09: centre mode: set-a match by direction only
// R10: out3 alt pin follows b when enabled
// R11: part b pin follows b when enabled
// R12: out2 alt pin follows a when enabled
// R13: part a pin follows a when enabled
// R14: compare values are twelve bits, always compared
// R15: high byte staged, low byte write commits
// R16: converter sync is a one-cycle pulse
module pwr_out_route
  import pwr_pkg::*;
(
  input  wire logic                                 sys_clk,
  input  wire logic                                 reset_n,
  input  wire logic [7:0]                           avs_address,
  input  wire logic                                 avs_read,
  input  wire logic                                 avs_write,
  input  wire logic [31:0]                          avs_writedata,
  input  wire logic [3:0]                           avs_byteenable,
  output logic [31:0]                               avs_readdata,
  output logic                                      avs_waitrequest,
  input  wire pwr_pkg::pwr_unit_in_s [NUM_UNITS-1:0] unit_in,
  output pwr_pkg::pwr_pins_s                        pins,
  output logic [NUM_UNITS-1:0]                      adc_sync,
  output logic                                      irq,
  output logic [2:0]                                irq_vector
);

  typedef struct packed {
    logic [NUM_UNITS-1:0][7:0]       cfg;
    logic [NUM_UNITS-1:0][3:0][15:0] cmp;
    logic [7:0]                      temp;
    logic [5:0]                      stat;
    logic [5:0]                      mask;
    logic                            waitreq;
    logic [31:0]                     rdata;
    logic                            irq;
    logic [2:0]                      vec;
    pwr_pins_s                       pins;
  } pwr_core_s;

  pwr_core_s  s_q;
  pwr_core_s  s_d;
  logic [5:0] events;
  logic       dec_ok;
  logic       dec_cfg;
  logic       dec_cmp;
  logic       dec_stat;
  logic       dec_mask;
  logic       dec_vec;
  logic [3:0] cmp_idx;
  logic [1:0] sel_unit;
  logic [1:0] sel_slot;
  logic [31:0] rd_val;
  logic       take;
  logic       wr_lane;

  // per-unit events and sync selectors
  genvar gk;
  generate
    for (gk = 0; gk < NUM_UNITS; gk++) begin : g_unit
      assign events[2*gk] = unit_in[gk].tick &&
        (unit_in[gk].cnt == s_q.cmp[gk][CMP_RB][CMP_BITS-1:0]); // R02 R14
      assign events[2*gk+1] = unit_in[gk].retrig || unit_in[gk].capture ||
        unit_in[gk].sync_err; // R03

      pwr_sync_sel u_sync (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .unit     (unit_in[gk]),
        .sel      (s_q.cfg[gk][CFG_SYNC_LO+1:CFG_SYNC_LO]),
        .sa       (s_q.cmp[gk][CMP_SA]),
        .ra       (s_q.cmp[gk][CMP_RA]),
        .sb       (s_q.cmp[gk][CMP_SB]),
        .rb       (s_q.cmp[gk][CMP_RB]),
        .adc_sync (adc_sync[gk])
      );
    end
  endgenerate

  // address decode and read mux
  always_comb begin
    cmp_idx  = avs_address[6:3] - 4'h4;
    sel_unit = cmp_idx[3:2];
    sel_slot = cmp_idx[1:0];
    dec_cfg  = (avs_address[7:4] == REG_CFG_BASE[7:4]) && (avs_address[3:2] != 2'b11)
               && (avs_address[1:0] == 2'b00);
    dec_cmp  = !avs_address[7] && (avs_address[6:5] != 2'b00)
               && (cmp_idx < CMP_SLOTS) && (avs_address[1:0] == 2'b00);
    dec_stat = (avs_address == REG_IRQ_STAT);
    dec_mask = (avs_address == REG_IRQ_MASK);
    dec_vec  = (avs_address == REG_IRQ_VEC);
    dec_ok   = dec_cfg || dec_cmp || dec_stat || dec_mask || dec_vec;
    rd_val   = '0;
    if (dec_cfg) begin
      rd_val[7:0] = s_q.cfg[avs_address[3:2]];
    end else if (dec_cmp) begin
      rd_val[7:0] = avs_address[2] ? s_q.cmp[sel_unit][sel_slot][15:8]
                                   : s_q.cmp[sel_unit][sel_slot][7:0];
    end else if (dec_stat) begin
      rd_val[5:0] = s_q.stat;
    end else if (dec_mask) begin
      rd_val[5:0] = s_q.mask;
    end else if (dec_vec) begin
      rd_val[2:0] = s_q.vec;
    end
  end

  // a request is served once, in the cycle waitrequest is still high
  assign take    = (avs_read || avs_write) && s_q.waitreq;
  assign wr_lane = take && avs_write && avs_byteenable[0];

  always_comb begin
    s_d = s_q;
    s_d.waitreq = !take;
    if (take && avs_read) begin
      s_d.rdata = rd_val;
    end

    // register writes; unmapped addresses are ignored
    if (wr_lane && dec_cfg) begin
      s_d.cfg[avs_address[3:2]] = avs_writedata[7:0];
    end
    if (wr_lane && dec_cmp && avs_address[2]) begin
      s_d.temp = avs_writedata[7:0]; // R15
    end
    if (wr_lane && dec_cmp && !avs_address[2]) begin
      // both bytes land together so the comparator never sees a torn value
      s_d.cmp[sel_unit][sel_slot] = {s_q.temp, avs_writedata[7:0]}; // R15
    end
    if (wr_lane && dec_mask) begin
      s_d.mask = avs_writedata[5:0]; // R02 R03
    end

    // sticky flags: a new event wins over a write-one clear
    s_d.stat = s_q.stat & ~((wr_lane && dec_stat) ? avs_writedata[5:0] : 6'h00);
    s_d.stat = s_d.stat | events; // R01

    // level interrupt and vector of the highest-priority pending source
    s_d.irq = |(s_q.stat & s_q.mask); // R01
    s_d.vec = VEC_NONE;
    for (int b = 0; b < 6; b++) begin
      if (s_q.stat[b] && s_q.mask[b]) begin
        s_d.vec = VEC_LAST - 3'(b); // R04
      end
    end

    // pin routing
    for (int k = 0; k < NUM_UNITS; k++) begin
      s_d.pins.wave_out_0_en[k] = s_q.cfg[k][CFG_PART_A_EN]; // R13
      s_d.pins.wave_out_0[k]    = s_q.cfg[k][CFG_PART_A_EN] && unit_in[k].wave_a; // R13
      s_d.pins.wave_out_1_en[k] = s_q.cfg[k][CFG_PART_B_EN]; // R11
      s_d.pins.wave_out_1[k]    = s_q.cfg[k][CFG_PART_B_EN] && unit_in[k].wave_b; // R11
    end
    s_d.pins.wave_out_2_en = s_q.cfg[2][CFG_OUT2_EN]; // R12
    s_d.pins.wave_out_2    = s_q.cfg[2][CFG_OUT2_EN] &&
      (s_q.cfg[2][CFG_OUT2_SEL] ? unit_in[2].wave_b : unit_in[2].wave_a); // R06 R12
    s_d.pins.wave_out_3_en = s_q.cfg[2][CFG_OUT3_EN]; // R10
    s_d.pins.wave_out_3    = s_q.cfg[2][CFG_OUT3_EN] &&
      (s_q.cfg[2][CFG_OUT3_SEL] ? unit_in[2].wave_a : unit_in[2].wave_b); // R05 R10
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_q         <= '0;
      s_q.cfg     <= {NUM_UNITS{CFG_RST}};
      s_q.cmp     <= {(NUM_UNITS*4){CMP_RST}};
      s_q.temp    <= TEMP_RST;
      s_q.stat    <= IRQ_RST;
      s_q.mask    <= IRQ_RST;
      s_q.waitreq <= 1'b1;
      s_q.vec     <= VEC_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata    = s_q.rdata;
  assign avs_waitrequest = s_q.waitreq;
  assign pins            = s_q.pins;
  assign irq             = s_q.irq;
  assign irq_vector      = s_q.vec;

  a_ec_sets_flag: assert property (@(posedge sys_clk) disable iff (!reset_n) // R02
    events[0] |=> s_q.stat[0])
    else $error("end-cycle event did not set its flag");

  a_capture_irq_sets_flag: assert property (@(posedge sys_clk) disable iff (!reset_n) // R03
    unit_in[1].sync_err |=> s_q.stat[3])
    else $error("sync error did not set capture flag");

  a_irq_follows: assert property (@(posedge sys_clk) disable iff (!reset_n) // R01
    (|(s_q.stat & s_q.mask)) |=> irq)
    else $error("irq low while an enabled flag is pending");

  a_vec_first: assert property (@(posedge sys_clk) disable iff (!reset_n) // R04
    (s_q.stat[5] && s_q.mask[5]) |=> (irq_vector == 3'h1))
    else $error("unit two capture must take vector one");

  a_out3_sel: assert property (@(posedge sys_clk) disable iff (!reset_n) // R05
    (s_q.cfg[2][CFG_OUT3_EN] && !s_q.cfg[2][CFG_OUT3_SEL])
    |=> (pins.wave_out_3 == $past(unit_in[2].wave_b)))
    else $error("out3 does not follow generator b");

  a_out2_sel: assert property (@(posedge sys_clk) disable iff (!reset_n) // R06
    (s_q.cfg[2][CFG_OUT2_EN] && s_q.cfg[2][CFG_OUT2_SEL])
    |=> (pins.wave_out_2 == $past(unit_in[2].wave_b)))
    else $error("out2 does not follow generator b");

  a_pin_release: assert property (@(posedge sys_clk) disable iff (!reset_n) // R13
    !s_q.cfg[0][CFG_PART_A_EN] |=> (!pins.wave_out_0_en[0] && !pins.wave_out_0[0]))
    else $error("part a pin driven while disabled");

  a_commit_pair: assert property (@(posedge sys_clk) disable iff (!reset_n) // R15
    (wr_lane && avs_address == REG_CMP_BASE)
    |=> (s_q.cmp[0][CMP_SA] == {$past(s_q.temp), $past(avs_writedata[7:0])}))
    else $error("compare pair not committed on low byte");

  a_wait_once: assert property (@(posedge sys_clk) disable iff (!reset_n)
    take |=> (!avs_waitrequest ##1 avs_waitrequest))
    else $error("waitrequest not low for exactly one cycle");

  // idle bus keeps waitrequest high, so a new request is always taken
  a_wait_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !(avs_read || avs_write)
    |=> avs_waitrequest)
    else $error("waitrequest low without a request");

  a_cfg_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (wr_lane && dec_cfg && avs_address[3:2] == 2'b10)
    |=> (s_q.cfg[2] == $past(avs_writedata[7:0])))
    else $error("unit two config write lost");

  a_mask_write: assert property (@(posedge sys_clk) disable iff (!reset_n) // R02 R03
    (wr_lane && dec_mask)
    |=> (s_q.mask == $past(avs_writedata[5:0])))
    else $error("mask write lost");

  a_temp_stage: assert property (@(posedge sys_clk) disable iff (!reset_n) // R15
    (wr_lane && dec_cmp && avs_address[2])
    |=> (s_q.temp == $past(avs_writedata[7:0])))
    else $error("high byte not staged");

  a_high_no_commit: assert property (@(posedge sys_clk) disable iff (!reset_n) // R15
    (wr_lane && dec_cmp && avs_address[2])
    |=> $stable(s_q.cmp))
    else $error("high byte write changed a compare value");

  // flags, level interrupt and vector
  a_ec_sets_u1: assert property (@(posedge sys_clk) disable iff (!reset_n) // R02
    events[2]
    |=> s_q.stat[2])
    else $error("unit one end-cycle flag not set");

  a_ec_sets_u2: assert property (@(posedge sys_clk) disable iff (!reset_n) // R02
    events[4]
    |=> s_q.stat[4])
    else $error("unit two end-cycle flag not set");

  a_capture_irq_retrig: assert property (@(posedge sys_clk) disable iff (!reset_n) // R03
    unit_in[0].retrig
    |=> s_q.stat[1])
    else $error("retrigger did not set capture flag");

  a_capture_irq_capture: assert property (@(posedge sys_clk) disable iff (!reset_n) // R03
    unit_in[2].capture
    |=> s_q.stat[5])
    else $error("capture did not set capture flag");

  a_stat_sticky: assert property (@(posedge sys_clk) disable iff (!reset_n) // R01
    (s_q.stat[0] && !(wr_lane && dec_stat && avs_writedata[0]))
    |=> s_q.stat[0])
    else $error("flag dropped without a write-one clear");

  a_irq_quiet: assert property (@(posedge sys_clk) disable iff (!reset_n) // R01
    !(|(s_q.stat & s_q.mask))
    |=> !irq)
    else $error("irq high with nothing enabled pending");

  a_vec_none: assert property (@(posedge sys_clk) disable iff (!reset_n) // R04
    !(|(s_q.stat & s_q.mask))
    |=> (irq_vector == VEC_NONE))
    else $error("vector set with nothing pending");

  a_vec_last: assert property (@(posedge sys_clk) disable iff (!reset_n) // R04
    ((s_q.stat & s_q.mask) == 6'h01)
    |=> (irq_vector == VEC_LAST))
    else $error("unit zero end-cycle must take the last vector");

  // pin ownership and routing
  a_out3_sel_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R05
    (s_q.cfg[2][CFG_OUT3_EN] && s_q.cfg[2][CFG_OUT3_SEL])
    |=> (pins.wave_out_3 == $past(unit_in[2].wave_a)))
    else $error("out3 does not follow generator a");

  a_out2_sel_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R06
    (s_q.cfg[2][CFG_OUT2_EN] && !s_q.cfg[2][CFG_OUT2_SEL])
    |=> (pins.wave_out_2 == $past(unit_in[2].wave_a)))
    else $error("out2 does not follow generator a");

  a_out3_release: assert property (@(posedge sys_clk) disable iff (!reset_n) // R10
    !s_q.cfg[2][CFG_OUT3_EN]
    |=> (!pins.wave_out_3_en && !pins.wave_out_3))
    else $error("out3 alt pin driven while disabled");

  a_out2_release: assert property (@(posedge sys_clk) disable iff (!reset_n) // R12
    !s_q.cfg[2][CFG_OUT2_EN]
    |=> (!pins.wave_out_2_en && !pins.wave_out_2))
    else $error("out2 alt pin driven while disabled");

  a_part_b_release: assert property (@(posedge sys_clk) disable iff (!reset_n) // R11
    !s_q.cfg[0][CFG_PART_B_EN]
    |=> (!pins.wave_out_1_en[0] && !pins.wave_out_1[0]))
    else $error("part b pin driven while disabled");

  a_part_b_follow: assert property (@(posedge sys_clk) disable iff (!reset_n) // R11
    s_q.cfg[1][CFG_PART_B_EN]
    |=> (pins.wave_out_1[1] == $past(unit_in[1].wave_b)))
    else $error("part b pin does not follow generator b");

  a_part_a_follow: assert property (@(posedge sys_clk) disable iff (!reset_n) // R13
    s_q.cfg[1][CFG_PART_A_EN]
    |=> (pins.wave_out_0[1] == $past(unit_in[1].wave_a)))
    else $error("part a pin does not follow generator a");

endmodule : pwr_out_route

`default_nettype wire

// >>> logic/pwr_pkg.sv
// shared constants and carriers for the waveform output routing block
// assumes a single 200 MHz clock and a synchronous active-low reset
package pwr_pkg;

  localparam int NUM_UNITS = 3;
  localparam int CMP_BITS  = 12;

  // register byte offsets on the bus
  localparam logic [7:0] REG_CFG_BASE = 8'h00;
  localparam logic [7:0] REG_CMP_BASE = 8'h20;
  localparam logic [7:0] REG_IRQ_STAT = 8'h80;
  localparam logic [7:0] REG_IRQ_MASK = 8'h84;
  localparam logic [7:0] REG_IRQ_VEC  = 8'h88;
  localparam logic [3:0] CMP_SLOTS    = 4'hc;

  // sync_output_config fields
  localparam int CFG_OUT3_SEL  = 7;
  localparam int CFG_OUT2_SEL  = 6;
  localparam int CFG_SYNC_LO   = 4;
  localparam int CFG_OUT3_EN   = 3;
  localparam int CFG_PART_B_EN = 2;
  localparam int CFG_OUT2_EN   = 1;
  localparam int CFG_PART_A_EN = 0;

  // compare register slots per unit
  localparam int CMP_SA = 0;
  localparam int CMP_RA = 1;
  localparam int CMP_SB = 2;
  localparam int CMP_RB = 3;

  localparam logic [7:0]  CFG_RST  = 8'h00;
  localparam logic [15:0] CMP_RST  = 16'h0000;
  localparam logic [7:0]  TEMP_RST = 8'h00;
  localparam logic [5:0]  IRQ_RST  = 6'h00;

  localparam logic [2:0] VEC_NONE = 3'h0;
  localparam logic [2:0] VEC_LAST = 3'h6;

  typedef enum logic [1:0] {
    PWR_ONE_RAMP  = 2'b00,
    PWR_TWO_RAMP  = 2'b01,
    PWR_FOUR_RAMP = 2'b10,
    PWR_CENTRE    = 2'b11
  } pwr_mode_e;

  typedef enum logic [1:0] {
    PWR_SYNC_A_LEAD  = 2'b00,
    PWR_SYNC_A_TRAIL = 2'b01,
    PWR_SYNC_B_LEAD  = 2'b10,
    PWR_SYNC_B_TRAIL = 2'b11
  } pwr_sync_e;

  // what the counter and ramp engine of one unit reports each cycle
  typedef struct packed {
    logic [11:0] cnt;
    logic        tick;
    logic        count_up;
    pwr_mode_e   mode;
    logic        wave_a;
    logic        wave_b;
    logic        fault_a;
    logic        fault_b;
    logic        retrig;
    logic        capture;
    logic        sync_err;
  } pwr_unit_in_s;

  typedef struct packed {
    logic [2:0] wave_out_0;
    logic [2:0] wave_out_0_en;
    logic [2:0] wave_out_1;
    logic [2:0] wave_out_1_en;
    logic       wave_out_2;
    logic       wave_out_2_en;
    logic       wave_out_3;
    logic       wave_out_3_en;
  } pwr_pins_s;

endpackage : pwr_pkg

// >>> logic/pwr_sync_sel.sv
// converter sync source selection for one waveform unit
// assumes compare values are stable registers of the parent
`timescale 1ns/100ps
`default_nettype none

module pwr_sync_sel
  import pwr_pkg::*;
(
  input  wire logic                     sys_clk,
  input  wire logic                     reset_n,
  input  wire pwr_pkg::pwr_unit_in_s    unit,
  input  wire logic [1:0]               sel,
  input  wire logic [15:0]              sa,
  input  wire logic [15:0]              ra,
  input  wire logic [15:0]              sb,
  input  wire logic [15:0]              rb,
  output logic                          adc_sync
);

  typedef struct packed {
    logic sync;
  } pwr_sync_s;

  pwr_sync_s s_q;
  pwr_sync_s s_d;
  logic      hit_sa;
  logic      hit_ra;
  logic      hit_sb;
  logic      hit_rb;

  assign hit_sa = unit.tick && (unit.cnt == sa[CMP_BITS-1:0]); // R14
  assign hit_ra = unit.tick && (unit.cnt == ra[CMP_BITS-1:0]);
  assign hit_sb = unit.tick && (unit.cnt == sb[CMP_BITS-1:0]);
  assign hit_rb = unit.tick && (unit.cnt == rb[CMP_BITS-1:0]);

  always_comb begin
    s_d = s_q;
    s_d.sync = 1'b0;
    if (unit.mode == PWR_CENTRE) begin
      unique case (sel)
        PWR_SYNC_A_LEAD:  s_d.sync = hit_sa && !unit.count_up; // R09
        PWR_SYNC_A_TRAIL: s_d.sync = hit_sa && unit.count_up; // R09
        PWR_SYNC_B_LEAD:  s_d.sync = 1'b0; // R09
        PWR_SYNC_B_TRAIL: s_d.sync = 1'b0; // R09
      endcase
    end else begin
      unique case (sel)
        PWR_SYNC_A_LEAD:  s_d.sync = hit_sa; // R07
        PWR_SYNC_A_TRAIL: s_d.sync = hit_ra || unit.fault_a; // R08
        PWR_SYNC_B_LEAD:  s_d.sync = hit_sb; // R07
        PWR_SYNC_B_TRAIL: s_d.sync = hit_rb || unit.fault_b; // R08
      endcase
    end
  end

  // one flop: the pulse lasts a single cycle per event
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d; // R16
    end
  end

  assign adc_sync = s_q.sync;

  a_centre_quiet: assert property (@(posedge sys_clk) disable iff (!reset_n) // R09
    (unit.mode == PWR_CENTRE && sel[1]) |=> !adc_sync)
    else $error("sync pulse in centre mode with a silent select code");

  a_lead_sa_sync: assert property (@(posedge sys_clk) disable iff (!reset_n) // R07
    (unit.mode != PWR_CENTRE && sel == PWR_SYNC_A_LEAD && hit_sa) |=> adc_sync)
    else $error("missing sync on set-a match");

  a_trail_b_sync: assert property (@(posedge sys_clk) disable iff (!reset_n) // R08
    (unit.mode != PWR_CENTRE && sel == PWR_SYNC_B_TRAIL && unit.fault_b) |=> adc_sync)
    else $error("missing sync on part b fault");

endmodule : pwr_sync_sel

`default_nettype wire

// >>> bench/pwr_eng_model.sv
// stand-in for the three counter and ramp engines beside the block
// assumes the bench calls set_mode and pulse_event from its own thread
`timescale 1ns/100ps
`default_nettype none
module pwr_eng_model
  import pwr_pkg::*;
(
  input  wire logic                              sys_clk,
  input  wire logic                              reset_n,
  output var  pwr_pkg::pwr_unit_in_s [NUM_UNITS-1:0] unit_in
);
  pwr_unit_in_s [NUM_UNITS-1:0] prev_q;
  pwr_mode_e                    mode_q;
  logic [11:0]                  cnt_q;
  logic                         ev_v;
  int                           ev_u;
  int                           ev_k;

  initial begin
    unit_in = '0;
    mode_q = PWR_ONE_RAMP;
    ev_v = 1'b0;
    ev_u = 0;
    ev_k = 0;
  end

  // 256-step period so any window of 256 cycles holds each match once
  always @(posedge sys_clk) begin
    prev_q <= unit_in;
    if (!reset_n || cnt_q == 12'h0ff) begin
      cnt_q <= 12'h000;
    end else begin
      cnt_q <= cnt_q + 12'h001;
    end
    for (int u = 0; u < NUM_UNITS; u++) begin
      unit_in[u] <= '0;
      unit_in[u].cnt <= cnt_q;
      unit_in[u].tick <= 1'b1;
      unit_in[u].count_up <= ~cnt_q[7];
      unit_in[u].mode <= mode_q;
      unit_in[u].wave_a <= cnt_q[3];
      unit_in[u].wave_b <= cnt_q[4];
      unit_in[u].retrig <= ev_v && ev_u == u && ev_k == 0;
      unit_in[u].capture <= ev_v && ev_u == u && ev_k == 1;
      unit_in[u].sync_err <= ev_v && ev_u == u && ev_k == 2;
      unit_in[u].fault_a <= ev_v && ev_u == u && ev_k == 3;
      unit_in[u].fault_b <= ev_v && ev_u == u && ev_k == 4;
    end
  end

  task automatic set_mode(input pwr_mode_e md);
    @(posedge sys_clk);
    mode_q <= md;
  endtask : set_mode

  // one-cycle event: kind 0 retrigger, 1 capture, 2 sync error, 3 fault a, 4 fault b
  task automatic pulse_event(input int u, input int k);
    @(posedge sys_clk);
    ev_u <= u;
    ev_k <= k;
    ev_v <= 1'b1;
    @(posedge sys_clk);
    ev_v <= 1'b0;
  endtask : pulse_event
endmodule : pwr_eng_model
`default_nettype wire

// >>> bench/pwr_out_route_tb_top.sv
// self-checking bench for the output routing block
// assumes the engine stand-in model and a 200 MHz clock
`timescale 1ns/100ps
`default_nettype none
module pwr_out_route_tb_top;
  import pwr_pkg::*;
  logic                         sys_clk;
  logic                         reset_n;
  logic [7:0]                   avs_address;
  logic                         avs_read;
  logic                         avs_write;
  logic [31:0]                  avs_writedata;
  logic [3:0]                   avs_byteenable;
  logic [31:0]                  avs_readdata;
  logic                         avs_waitrequest;
  pwr_unit_in_s [NUM_UNITS-1:0] unit_in;
  pwr_pins_s                    pins;
  logic [NUM_UNITS-1:0]         adc_sync;
  logic                         irq;
  logic [2:0]                   irq_vector;
  logic [31:0]                  rd;
  int                           n_errors;
  int                           checks_done;
  int                           cycles;

  pwr_out_route dut (.sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .unit_in(unit_in), .pins(pins),
    .adc_sync(adc_sync), .irq(irq), .irq_vector(irq_vector));
  pwr_eng_model m (.sys_clk(sys_clk), .reset_n(reset_n), .unit_in(unit_in));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // whole run needs about 2500 cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    chk(avs_waitrequest, 32'h0000_0000);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00, 4'h1);
    chk(rd, exp);
  endtask : rdc

  // high byte first into the shared staging byte, low byte commits
  task automatic wcmp(input int u, input int s, input logic [11:0] v);
    logic [7:0] a;
    a = 8'(32 + (u * 4 + s) * 8);
    wr(a + 8'h04, {4'h0, v[11:8]});
    wr(a, v[7:0]);
  endtask : wcmp

  task automatic t_regs();
    rdc(8'h00, 32'h0000_0000);
    rdc(8'h08, 32'h0000_0000);
    rdc(8'h3c, 32'h0000_0000);
    wr(8'h04, 8'h5a);
    rdc(8'h04, 32'h0000_005a);
    bus(1'b1, 8'h04, 8'hff, 4'h0);
    rdc(8'h04, 32'h0000_005a);
    rdc(8'h06, 32'h0000_0000);
    rdc(8'h90, 32'h0000_0000);
    wr(8'h24, 8'h05);
    rdc(8'h24, 32'h0000_0000);
    wr(8'h20, 8'h10);
    rdc(8'h24, 32'h0000_0005);
    rdc(8'h20, 32'h0000_0010);
    wr(8'h04, 8'h00);
  endtask : t_regs

  // one period of 256 cycles: count cycles with the sync pulse high
  task automatic t_sync();
    logic [1:0] md [8] = '{0, 0, 1, 2, 3, 3, 3, 3};
    logic [1:0] cd [8] = '{0, 1, 2, 3, 0, 1, 2, 3};
    int         ex [8] = '{1, 1, 1, 1, 0, 1, 0, 0};
    int         n;
    wcmp(0, CMP_SA, 12'h010);
    wcmp(0, CMP_RA, 12'h020);
    wcmp(0, CMP_SB, 12'h030);
    wcmp(0, CMP_RB, 12'h040);
    for (int i = 0; i < 8; i++) begin
      m.set_mode(pwr_mode_e'(md[i]));
      wr(8'h00, {2'b00, cd[i], 4'h0});
      repeat (4) @(posedge sys_clk);
      n = 0;
      repeat (256) begin
        @(posedge sys_clk);
        if (adc_sync[0] === 1'b1) n++;
      end
      chk(n, ex[i]);
    end
    // reset matches moved out of reach so only the fault can fire the sync
    wcmp(0, CMP_RA, 12'h200);
    wcmp(0, CMP_RB, 12'h200);
    m.set_mode(PWR_ONE_RAMP);
    for (int j = 0; j < 2; j++) begin
      wr(8'h00, j ? 8'h30 : 8'h10);
      repeat (2) @(posedge sys_clk);
      m.pulse_event(0, 3 + j);
      n = 0;
      repeat (6) begin
        @(posedge sys_clk);
        if (adc_sync[0] === 1'b1) n++;
      end
      chk(n, 1);
    end
  endtask : t_sync

  task automatic t_pins();
    logic [7:0] cf [4] = '{8'h00, 8'h0f, 8'hcf, 8'h45};
    logic [7:0] c;
    logic       a;
    logic       b;
    for (int i = 0; i < 4; i++) begin
      c = cf[i];
      wr(8'h08, c);
      repeat (3) @(posedge sys_clk);
      repeat (40) begin
        @(negedge sys_clk);
        a = m.prev_q[2].wave_a;
        b = m.prev_q[2].wave_b;
        chk({pins.wave_out_0[2], pins.wave_out_0_en[2], pins.wave_out_1[2],
             pins.wave_out_1_en[2], pins.wave_out_2, pins.wave_out_2_en,
             pins.wave_out_3, pins.wave_out_3_en},
            {c[0] & a, c[0], c[2] & b, c[2], c[1] & (c[6] ? b : a), c[1],
             c[3] & (c[7] ? a : b), c[3]});
      end
    end
    wr(8'h00, 8'h05);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({pins.wave_out_0[0], pins.wave_out_0_en[0], pins.wave_out_1[0],
         pins.wave_out_1_en[0], pins.wave_out_0_en[1], pins.wave_out_1_en[1]},
        {m.prev_q[0].wave_a, 1'b1, m.prev_q[0].wave_b, 1'b1, 2'b00});
  endtask : t_pins

  task automatic t_irq();
    logic [7:0] clr [3] = '{8'h20, 8'h08, 8'h02};
    logic [2:0] vx [4] = '{3'h1, 3'h3, 3'h5, 3'h6};
    wr(8'h84, 8'h00);
    for (int k = 0; k < 3; k++) m.pulse_event(k, k);
    repeat (3) @(posedge sys_clk);
    bus(1'b0, 8'h80, 8'h00, 4'h1);
    chk(rd & 32'h0000_002b, 32'h0000_002b);
    chk(irq, 32'h0000_0000);
    wr(8'h84, 8'h2b);
    for (int i = 0; i < 4; i++) begin
      repeat (2) @(posedge sys_clk);
      chk(irq_vector, vx[i]);
      rdc(8'h88, vx[i]);
      chk(irq, 32'h0000_0001);
      if (i < 3) wr(8'h80, clr[i]);
    end
    wr(8'h84, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk(irq, 32'h0000_0000);
  endtask : t_irq

  initial begin
    n_errors = 0;
    checks_done = 0;
    cycles = 0;
    reset_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    t_regs();
    t_sync();
    t_pins();
    t_irq();
    give_verdict();
  end
endmodule : pwr_out_route_tb_top
`default_nettype wire
